//--- core/gpio_exp_pkg.sv
// Constants shared by the GPIO expander port core
package gpio_exp_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_DIR   = 4'h0;
  localparam logic [3:0] ADDR_IPOL  = 4'h1;
  localparam logic [3:0] ADDR_INTEN = 4'h2;
  localparam logic [3:0] ADDR_DEFV  = 4'h3;
  localparam logic [3:0] ADDR_INTCN = 4'h4;
  localparam logic [3:0] ADDR_CFG   = 4'h5;
  localparam logic [3:0] ADDR_PULL  = 4'h6;
  localparam logic [3:0] ADDR_FLAG  = 4'h7;
  localparam logic [3:0] ADDR_CAP   = 4'h8;
  localparam logic [3:0] ADDR_PORT  = 4'h9;
  localparam logic [3:0] ADDR_OLAT  = 4'ha;
  localparam logic [3:0] ADDR_LAST  = 4'ha;
  localparam logic [3:0] ADDR_PTR   = 4'he;
  localparam logic [3:0] ADDR_DATA  = 4'hf;
  // ----------------------------------------------------------------
  // Field positions in the configuration register
  // ----------------------------------------------------------------
  localparam int CFG_INT_POL = 1;
  localparam int CFG_INT_OD  = 2;
  localparam int CFG_SEQ_DIS = 5;
  // ----------------------------------------------------------------
  // Reset values and address base
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DIR   = 8'hff;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [3:0] RST_PTR   = 4'h0;
  localparam logic [3:0] SLAVE_BASE = 4'h4;
endpackage

//--- core/gpio_exp_port.sv
// GPIO expander port core: registers, open-drain pins and interrupt
// Functional notes
// - One port of eight pins, each usable as input or output.
// - After reset all pins are inputs and drive nothing.
// - Inputs kept in port register, outputs in output latch register.
// - Output pins only pull low or release, never drive high.
// - Polarity bit inverts the port register value of its pin.
// - Per-pin interrupt enable and pull-up enable, independent of each other.
// - Change mode flags an enabled input differing from port register.
// - Compare mode flags an enabled input differing from compare value.
// - On interrupt the port value is copied into capture register.
// - Interrupt pin is active-high, active-low, or open-drain.
// - Reset loads every register default and idles internal state.
// - Slave address comes from the hardware address pin level.
// - Every register reads back its current contents.
// - Eleven registers at 0x00 to 0x0a; capture register is read-only.
// - Sequential mode advances pointer and wraps to 0; byte mode holds.
//
// Chosen here: the placing of the registers and the plain strobed port.
module gpio_exp_port (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_ext_rst_n,
  // Register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  output logic      [7:0] o_rd_data,
  // Port pins
  input  wire logic [7:0] i_pin_in,
  output logic      [7:0] o_pin_out,
  output logic      [7:0] o_pin_oe,
  output logic      [7:0] o_pullup_en,
  // Interrupt pin
  output logic            o_int_out,
  output logic            o_int_oe,
  // Address strap
  input  wire logic [2:0] i_hw_addr,
  output logic      [6:0] o_slave_addr
);
  // ----------------------------------------------------------------
  // Synchronisers and combined reset
  // ----------------------------------------------------------------
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;
  logic [2:0] adr_s1_q;
  logic [2:0] adr_s2_q;
  logic       xrst_s1_q;
  logic       xrst_s2_q;
  logic       rst;

  // two-stage sync
  // Pins and strap come from outside this clock domain
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pin_s1_q  <= 8'h00;
      pin_s2_q  <= 8'h00;
      adr_s1_q  <= 3'h0;
      adr_s2_q  <= 3'h0;
      xrst_s1_q <= 1'b0;
      xrst_s2_q <= 1'b0;
    end else begin
      pin_s1_q  <= i_pin_in;
      pin_s2_q  <= pin_s1_q;
      adr_s1_q  <= i_hw_addr;
      adr_s2_q  <= adr_s1_q;
      xrst_s1_q <= ~i_ext_rst_n;
      xrst_s2_q <= xrst_s1_q;
    end
  end

  assign rst = i_sys_rst | xrst_s2_q;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] dir_q;
  logic [7:0] ipol_q;
  logic [7:0] inten_q;
  logic [7:0] defv_q;
  logic [7:0] intcn_q;
  logic [7:0] cfg_q;
  logic [7:0] pull_q;
  logic [7:0] olat_q;
  logic [3:0] ptr_q;
  logic [3:0] ptr_d;
  logic       acc;
  logic [3:0] tgt;
  logic       wr;

  // Data port accesses go through the pointer
  assign acc = i_wr_en | i_rd_en;
  assign tgt = (i_addr == gpio_exp_pkg::ADDR_DATA) ? ptr_q : i_addr;
  assign wr  = i_wr_en;

  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      dir_q   <= gpio_exp_pkg::RST_DIR;
      ipol_q  <= gpio_exp_pkg::RST_ZERO;
      inten_q <= gpio_exp_pkg::RST_ZERO;
      defv_q  <= gpio_exp_pkg::RST_ZERO;
      intcn_q <= gpio_exp_pkg::RST_ZERO;
      cfg_q   <= gpio_exp_pkg::RST_ZERO;
      pull_q  <= gpio_exp_pkg::RST_ZERO;
      olat_q  <= gpio_exp_pkg::RST_ZERO;
    end else if (wr) begin
      case (tgt)
        gpio_exp_pkg::ADDR_DIR:   dir_q   <= i_wr_data;
        gpio_exp_pkg::ADDR_IPOL:  ipol_q  <= i_wr_data;
        gpio_exp_pkg::ADDR_INTEN: inten_q <= i_wr_data;
        gpio_exp_pkg::ADDR_DEFV:  defv_q  <= i_wr_data;
        gpio_exp_pkg::ADDR_INTCN: intcn_q <= i_wr_data;
        gpio_exp_pkg::ADDR_CFG:   cfg_q   <= i_wr_data;
        gpio_exp_pkg::ADDR_PULL:  pull_q  <= i_wr_data;
        gpio_exp_pkg::ADDR_OLAT:  olat_q  <= i_wr_data;
        default: ;                // Capture is read-only, flags are write-one-clear
      endcase
    end
  end

  // pointer advance and wrap
  // Byte mode keeps polling one register without re-addressing
  always_comb begin
    ptr_d = ptr_q;
    if (i_wr_en && i_addr == gpio_exp_pkg::ADDR_PTR) begin
      ptr_d = i_wr_data[3:0];
    end else if (acc && i_addr == gpio_exp_pkg::ADDR_DATA && !cfg_q[gpio_exp_pkg::CFG_SEQ_DIS]) begin
      ptr_d = (ptr_q >= gpio_exp_pkg::ADDR_LAST) ? gpio_exp_pkg::RST_PTR : ptr_q + 4'h1;
    end
  end

  // Address pointer
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      ptr_q <= gpio_exp_pkg::RST_PTR;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // ----------------------------------------------------------------
  // Port register and interrupt detection
  // ----------------------------------------------------------------
  logic [7:0] pin_val;
  logic [7:0] port_q;
  logic [7:0] flag_q;
  logic [7:0] cap_q;
  logic [7:0] diff;
  logic [7:0] evt;
  logic [7:0] clr;
  logic       int_act;

  assign pin_val = pin_s2_q ^ ipol_q;

  // change mode compares with port register
  // compare mode per pin selected by control bit
  assign diff = intcn_q & (pin_val ^ defv_q) | ~intcn_q & (pin_val ^ port_q);
  // only enabled input pins raise events
  assign evt  = diff & inten_q & dir_q;
  assign clr  = (wr && tgt == gpio_exp_pkg::ADDR_FLAG) ? i_wr_data : 8'h00;

  // input port register follows the pins
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      port_q <= gpio_exp_pkg::RST_ZERO;
    end else begin
      port_q <= pin_val;
    end
  end

  // Sticky flags; a new event wins over a same-cycle clear
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      flag_q <= gpio_exp_pkg::RST_ZERO;
    end else begin
      flag_q <= (flag_q & ~clr) | evt;
    end
  end

  // capture on the first event only
  // Later events must not overwrite the cause until flags clear
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      cap_q <= gpio_exp_pkg::RST_ZERO;
    end else if (flag_q == 8'h00 && evt != 8'h00) begin
      cap_q <= pin_val;
    end
  end

  // Enable register doubles as the interrupt mask
  assign int_act = |(flag_q & inten_q);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] rd_d;

  always_comb begin
    case (tgt)
      gpio_exp_pkg::ADDR_DIR:   rd_d = dir_q;
      gpio_exp_pkg::ADDR_IPOL:  rd_d = ipol_q;
      gpio_exp_pkg::ADDR_INTEN: rd_d = inten_q;
      gpio_exp_pkg::ADDR_DEFV:  rd_d = defv_q;
      gpio_exp_pkg::ADDR_INTCN: rd_d = intcn_q;
      gpio_exp_pkg::ADDR_CFG:   rd_d = cfg_q;
      gpio_exp_pkg::ADDR_PULL:  rd_d = pull_q;
      gpio_exp_pkg::ADDR_FLAG:  rd_d = flag_q;
      gpio_exp_pkg::ADDR_CAP:   rd_d = cap_q;
      gpio_exp_pkg::ADDR_PORT:  rd_d = port_q;
      gpio_exp_pkg::ADDR_OLAT:  rd_d = olat_q;
      gpio_exp_pkg::ADDR_PTR:   rd_d = {4'h0, ptr_q};
      default:                  rd_d = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= i_rd_en ? rd_d : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Pin and interrupt drivers
  // ----------------------------------------------------------------
  // eight independent pins
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      o_pin_out   <= 8'h00;
      o_pin_oe    <= 8'h00;
      o_pullup_en <= 8'h00;
    end else begin
      o_pin_out   <= 8'h00;
      o_pin_oe    <= ~dir_q & ~olat_q;
      o_pullup_en <= pull_q;
    end
  end

  // three interrupt pin styles
  // Open drain ignores polarity: it can only pull low when active
  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      o_int_out <= 1'b1;
      o_int_oe  <= 1'b1;
    end else if (cfg_q[gpio_exp_pkg::CFG_INT_OD]) begin
      o_int_out <= 1'b0;
      o_int_oe  <= int_act;
    end else begin
      o_int_out <= cfg_q[gpio_exp_pkg::CFG_INT_POL] ? int_act : ~int_act;
      o_int_oe  <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (rst) begin
      o_slave_addr <= {gpio_exp_pkg::SLAVE_BASE, 3'h0};
    end else begin
      o_slave_addr <= {gpio_exp_pkg::SLAVE_BASE, adr_s2_q};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  a_reset_no_drive: assert property ($past(rst) |-> o_pin_oe == 8'h00)
    else $error("pin driven right after reset");
  a_never_high: assert property (o_pin_out == 8'h00)
    else $error("pin driven high");
  a_drive_latch: assert property (!rst ##1 !rst |-> o_pin_oe == ($past(~dir_q) & $past(~olat_q)))
    else $error("pin enable not from direction and latch");
  a_polarity_inv: assert property (!rst |=> port_q == ($past(pin_s2_q) ^ $past(ipol_q)))
    else $error("port register polarity wrong");
  a_change_flag: assert property (!rst && !clr[0] && inten_q[0] && dir_q[0] && !intcn_q[0]
                                  && pin_val[0] != port_q[0] |=> flag_q[0])
    else $error("change event lost");
  a_compare_flag: assert property (!rst && inten_q[0] && dir_q[0] && intcn_q[0]
                                   && pin_val[0] != defv_q[0] |=> flag_q[0])
    else $error("compare event lost");
  a_capture_val: assert property (!rst && flag_q == 8'h00 && evt != 8'h00 |=> cap_q == $past(pin_val))
    else $error("capture missed");
  a_int_style: assert property (!rst && int_act && !cfg_q[gpio_exp_pkg::CFG_INT_OD]
                                && !cfg_q[gpio_exp_pkg::CFG_INT_POL] |=> !o_int_out && o_int_oe)
    else $error("active-low interrupt wrong");
  a_ptr_wrap: assert property (!rst && acc && i_addr == gpio_exp_pkg::ADDR_DATA && ptr_q == gpio_exp_pkg::ADDR_LAST
                               && !cfg_q[gpio_exp_pkg::CFG_SEQ_DIS] |=> ptr_q == 4'h0)
    else $error("pointer did not wrap");
  a_read_back: assert property (!rst && i_rd_en && i_addr == gpio_exp_pkg::ADDR_DIR |=> o_rd_data == $past(dir_q))
    else $error("read data mismatch");
  a_ext_reset: assert property (xrst_s2_q |=> dir_q == gpio_exp_pkg::RST_DIR && flag_q == 8'h00)
    else $error("pin reset ignored");

  // ----------------------------------------------------------------
  // Guards on flags, pin styles, pointer and read port
  // ----------------------------------------------------------------
  // clear never hides event
  a_flag_set_wins: assert property (!rst && evt != 8'h00 |=> (flag_q & $past(evt)) == $past(evt))
    else $error("event lost to a clear");
  a_od_int: assert property (!rst && cfg_q[gpio_exp_pkg::CFG_INT_OD]
                             |=> !o_int_out && o_int_oe == $past(int_act))
    else $error("open-drain interrupt wrong");
  a_high_int: assert property (!rst && cfg_q[gpio_exp_pkg::CFG_INT_POL]
                               && !cfg_q[gpio_exp_pkg::CFG_INT_OD] |=> o_int_out == $past(int_act) && o_int_oe)
    else $error("active-high interrupt wrong");
  a_byte_hold: assert property (!rst && acc && i_addr == gpio_exp_pkg::ADDR_DATA
                                && cfg_q[gpio_exp_pkg::CFG_SEQ_DIS] |=> ptr_q == $past(ptr_q))
    else $error("pointer moved in byte mode");
  a_cap_readonly: assert property (!rst && i_wr_en && i_addr == gpio_exp_pkg::ADDR_CAP
                                   && (flag_q != 8'h00 || evt == 8'h00) |=> $stable(cap_q))
    else $error("capture register written");
  a_rd_idle: assert property (!rst && !i_rd_en |=> o_rd_data == 8'h00)
    else $error("read data outside answer cycle");
  a_slave_strap: assert property (!rst |=> o_slave_addr == {gpio_exp_pkg::SLAVE_BASE, $past(adr_s2_q)})
    else $error("slave address not from strap");
  a_pull_follow: assert property (!rst |=> o_pullup_en == $past(pull_q))
    else $error("pull-up enable wrong");

  // Main scenarios that the run should reach
  c_int_fire: cover property (!int_act ##1 int_act);
  c_ptr_wrap: cover property (ptr_q == gpio_exp_pkg::ADDR_LAST ##1 ptr_q == 4'h0);
  c_pin_drive: cover property (o_pin_oe != 8'h00);
  c_od_int: cover property (cfg_q[gpio_exp_pkg::CFG_INT_OD] && o_int_oe);
  c_byte_hold: cover property (acc && i_addr == gpio_exp_pkg::ADDR_DATA && cfg_q[gpio_exp_pkg::CFG_SEQ_DIS]);
endmodule

//--- verif/gpio_exp_port_bench.sv
// Self-checking bench for the GPIO expander port core
module gpio_exp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       ext_rst_n = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [7:0] rd_data, pin_in, pin_out, pin_oe, pullup_en;
  logic       int_out, int_oe;
  logic [2:0] hw_addr = 3'h5;
  logic [6:0] slave_addr;
  logic [7:0] ext_lvl = 8'h00;
  logic [7:0] ext_en = 8'hff;
  int         failures = 0;
  int         total_checks = 0;

  // 25 MHz core clock
  always #20 clk = ~clk;

  gpio_exp_port dut (.i_core_clk(clk), .i_sys_rst(sys_rst), .i_ext_rst_n(ext_rst_n), .i_addr(addr),
    .i_wr_data(wr_data), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data), .i_pin_in(pin_in),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pullup_en(pullup_en), .o_int_out(int_out),
    .o_int_oe(int_oe), .i_hw_addr(hw_addr), .o_slave_addr(slave_addr));

  gpio_pin_model pins (.i_core_clk(clk), .i_pin_oe(pin_oe), .i_pullup_en(pullup_en),
    .i_ext_lvl(ext_lvl), .i_ext_en(ext_en), .o_pin_lvl(pin_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask

  task automatic pins_to(input logic [7:0] v);
    @(posedge clk);
    ext_lvl <= v;
  endtask

  // Interrupt pin packed as {oe, out}
  task automatic int_chk(input logic [1:0] exp);
    #1 chk({6'h00, int_oe, int_out}, {6'h00, exp});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    // Defaults after reset, unmapped address reads zero
    rd_chk(gpio_exp_pkg::ADDR_DIR, gpio_exp_pkg::RST_DIR);
    for (int a = 1; a <= 10; a++) rd_chk(4'(a), 8'h00);
    rd_chk(4'hb, 8'h00);
    chk(pin_oe, 8'h00);
    chk({1'b0, slave_addr}, 8'h25);
    int_chk(2'b11);
    $display("test defaults done");
    // Open-drain outputs follow direction and output latch
    wr(gpio_exp_pkg::ADDR_DIR, 8'hf0);
    wr(gpio_exp_pkg::ADDR_OLAT, 8'h05);
    repeat (2) @(posedge clk);
    #1 chk(pin_oe, 8'h0a);
    chk(pin_out, 8'h00);
    rd_chk(gpio_exp_pkg::ADDR_OLAT, 8'h05);
    pins_to(8'hff);
    repeat (5) @(posedge clk);
    rd_chk(gpio_exp_pkg::ADDR_PORT, 8'hf5);
    wr(gpio_exp_pkg::ADDR_DIR, 8'hff);
    pins_to(8'ha5);
    wr(gpio_exp_pkg::ADDR_IPOL, 8'h0f);
    repeat (4) @(posedge clk);
    rd_chk(gpio_exp_pkg::ADDR_PORT, 8'haa);
    wr(gpio_exp_pkg::ADDR_IPOL, 8'h00);
    wr(gpio_exp_pkg::ADDR_PULL, 8'h3c);
    repeat (2) @(posedge clk);
    #1 chk(pullup_en, 8'h3c);
    $display("test pins done");
    // Change mode: pin 0 enabled, pin 1 not
    wr(gpio_exp_pkg::ADDR_INTEN, 8'h01);
    pins_to(8'ha4);
    repeat (8) @(posedge clk);
    rd_chk(gpio_exp_pkg::ADDR_FLAG, 8'h01);
    rd_chk(gpio_exp_pkg::ADDR_CAP, 8'ha4);
    int_chk(2'b10);
    wr(gpio_exp_pkg::ADDR_CAP, 8'hff);
    rd_chk(gpio_exp_pkg::ADDR_CAP, 8'ha4);
    wr(gpio_exp_pkg::ADDR_FLAG, 8'h01);
    pins_to(8'ha6);
    repeat (8) @(posedge clk);
    rd_chk(gpio_exp_pkg::ADDR_FLAG, 8'h00);
    int_chk(2'b11);
    $display("test change done");
    // Compare mode on pin 1 against a zero default
    wr(gpio_exp_pkg::ADDR_INTCN, 8'h02);
    wr(gpio_exp_pkg::ADDR_INTEN, 8'h02);
    repeat (8) @(posedge clk);
    rd_chk(gpio_exp_pkg::ADDR_FLAG, 8'h02);
    rd_chk(gpio_exp_pkg::ADDR_CAP, 8'ha6);
    wr(gpio_exp_pkg::ADDR_CFG, 8'h02);
    repeat (2) @(posedge clk);
    int_chk(2'b11);
    wr(gpio_exp_pkg::ADDR_CFG, 8'h04);
    wr(gpio_exp_pkg::ADDR_FLAG, 8'h02);
    repeat (3) @(posedge clk);
    int_chk(2'b10);
    wr(gpio_exp_pkg::ADDR_INTEN, 8'h00);
    wr(gpio_exp_pkg::ADDR_FLAG, 8'h02);
    repeat (3) @(posedge clk);
    rd_chk(gpio_exp_pkg::ADDR_FLAG, 8'h00);
    int_chk(2'b00);
    $display("test compare done");
    // Address pointer: wrap in sequential mode, hold in byte mode
    wr(gpio_exp_pkg::ADDR_CFG, 8'h00);
    wr(gpio_exp_pkg::ADDR_PTR, 8'h0a);
    rd_chk(gpio_exp_pkg::ADDR_DATA, 8'h05);
    rd_chk(gpio_exp_pkg::ADDR_PTR, 8'h00);
    wr(gpio_exp_pkg::ADDR_DATA, 8'h00);
    rd_chk(gpio_exp_pkg::ADDR_PTR, 8'h01);
    wr(gpio_exp_pkg::ADDR_CFG, 8'h20);
    wr(gpio_exp_pkg::ADDR_PTR, 8'h04);
    rd_chk(gpio_exp_pkg::ADDR_DATA, 8'h02);
    rd_chk(gpio_exp_pkg::ADDR_PTR, 8'h04);
    $display("test pointer done");
    // External reset pin restores defaults
    @(posedge clk);
    ext_rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    ext_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(gpio_exp_pkg::ADDR_DIR, gpio_exp_pkg::RST_DIR);
    rd_chk(gpio_exp_pkg::ADDR_CFG, 8'h00);
    rd_chk(gpio_exp_pkg::ADDR_PULL, 8'h00);
    $display("test external reset done");
    summarize();
  end

  // Hang guard well beyond the longest sequence
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule

//--- verif/gpio_pin_model.sv
// Pin-side partner: open-drain port wires with pull-ups and outside drivers
module gpio_pin_model (
  // Clock for the floating-wire pattern
  input  wire logic       i_core_clk,
  // Device side of the wires
  input  wire logic [7:0] i_pin_oe,
  input  wire logic [7:0] i_pullup_en,
  // Outside drivers
  input  wire logic [7:0] i_ext_lvl,
  input  wire logic [7:0] i_ext_en,
  // Resolved wire levels
  output logic      [7:0] o_pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_q = 8'h55;

  // A wire nobody drives toggles, so a stale value is never mistaken for data
  always @(posedge i_core_clk) begin
    float_q <= ~float_q;
  end

  // Wire resolution: a sink beats all, then outside drivers, then pull-ups
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // sink only, never a high drive
      if (i_pin_oe[i]) o_pin_lvl[i] = 1'b0;
      else if (i_ext_en[i]) o_pin_lvl[i] = i_ext_lvl[i];
      // pull-up holds an undriven wire high
      else if (i_pullup_en[i]) o_pin_lvl[i] = 1'b1;
      else o_pin_lvl[i] = float_q[i];
    end
  end
endmodule
